// ---- inc/ccr_pkg.sv ----
// Constants for the channel control register set.
// Assumes a single 250 MHz clock and odd byte parity throughout.

package ccr_pkg;

  // ====================================================================
  // Widths
  localparam int BYTE_W = 8;
  localparam int CTL_BYTES = 8;
  localparam int CTL_W = BYTE_W * CTL_BYTES;

  // ====================================================================
  // Parity and reset values
  localparam logic [7:0] BYTE_CLEAR = 8'h00;
  localparam logic PAR_CLEAR = 1'b1;

  // ====================================================================
  // Local store word codes
  localparam logic [1:0] WORD0 = 2'h0;
  localparam logic [1:0] WORD1 = 2'h1;
  localparam logic [1:0] WORD2 = 2'h2;
  localparam logic [1:0] WORD3 = 2'h3;
  localparam logic [7:0] LS_FIRST_ADDR = 8'h00;
  localparam logic [7:0] LS_LAST_ADDR = 8'hff;

  // ====================================================================
  // Control register contents
  typedef enum logic [2:0] {
    CTL_EMPTY = 3'h0,
    CTL_CAW = 3'h1,
    CTL_CSW_W0 = 3'h2,
    CTL_UCW1 = 3'h3,
    CTL_CSW_W2 = 3'h4,
    CTL_CSW_W3 = 3'h5
  } ccr_ctl_kind_type;

  // ====================================================================
  // Master reset sequencer
  typedef enum logic [1:0] {
    MR_IDLE = 2'h0,
    MR_TIMING = 2'h1,
    MR_SWEEP = 2'h2,
    MR_PULSE = 2'h3
  } ccr_mr_state_type;

  // ====================================================================
  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int MR_TIME_US = 6;
  localparam int MR_PULSE_US = 2;
  // Least time rounds up, pulse length rounds down
  localparam int MR_CYCLES_I = (MR_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MR_PULSE_CYCLES_I = (MR_PULSE_US * 1000000) / CLK_PERIOD_PS;
  localparam logic [10:0] MR_CYCLES = 11'(MR_CYCLES_I);
  localparam logic [10:0] MR_PULSE_CYCLES = 11'(MR_PULSE_CYCLES_I);
  localparam logic [10:0] CNT_ZERO = 11'h000;
  localparam logic [10:0] CNT_ONE = 11'h001;

endpackage : ccr_pkg

// ---- rtl/ccr_byte_reg.sv ----
// One byte register with odd parity, cleared by master reset.
// Assumes clear and load come from the same clock domain.
`timescale 1ns/100ps
`default_nettype none

module ccr_byte_reg (
  input wire logic i_clk,
  input wire logic i_clear,
  input wire logic i_load,
  input wire logic [7:0] i_data,
  output logic [8:0] o_byte
);

  // ====================================================================
  // Storage
  logic [7:0] data_reg;
  logic par_reg;

  // No machine reset here: only master reset or a load alters contents
  always_ff @(posedge i_clk) begin
    if (i_clear) begin
      data_reg <= ccr_pkg::BYTE_CLEAR;
      par_reg <= ccr_pkg::PAR_CLEAR;
    end else if (i_load) begin
      data_reg <= i_data;
      par_reg <= ~^i_data;
    end
  end

  assign o_byte = {par_reg, data_reg};

endmodule : ccr_byte_reg
`default_nettype wire

// ---- rtl/ccr_channel_regs.sv ----
// Channel control register set with master reset storage clear.
// Assumes all strobes are one-cycle pulses synchronous to i_clk.
`timescale 1ns/100ps
`default_nettype none

module ccr_channel_regs (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_master_reset,
  input wire logic i_caw_load,
  input wire logic [63:0] i_caw_data,
  input wire logic i_ls_fetch_to_ctl,
  input wire logic i_manual_ls_fetch,
  input wire logic [63:0] i_ls_rdata,
  input wire logic i_ls_op,
  input wire logic [1:0] i_ls_word,
  input wire logic i_diag_ls_test,
  input wire logic i_sim_mode,
  input wire logic i_mpx_sim_write,
  input wire logic [7:0] i_mpx_sim_data,
  input wire logic i_ssc_sim_write,
  input wire logic [7:0] i_ssc_sim_data,
  input wire logic i_start_ccw_fetch,
  input wire logic i_chain_ccw_fetch,
  input wire logic [7:0] i_ccw_cmd,
  input wire logic i_login2,
  input wire logic [7:0] i_log_addr,
  input wire logic i_ibf_set,
  input wire logic [7:0] i_ibf_addr,
  input wire logic i_cpu_ua_load,
  input wire logic [7:0] i_cpu_unit_address_lines,
  input wire logic i_pseudo_test_io,
  input wire logic i_mpx_init_sel,
  input wire logic i_svc_req,
  input wire logic [7:0] i_bus_in,
  input wire logic i_seq_cpu,
  input wire logic i_seq_mpx,
  input wire logic i_seq_ssc,
  input wire logic [7:0] i_ssc_ua,
  output logic [63:0] o_ctl_data,
  output logic [7:0] o_ctl_par,
  output logic [2:0] o_ctl_kind,
  output logic [8:0] o_mpx_sim,
  output logic [8:0] o_ssc_sim,
  output logic [8:0] o_cmd,
  output logic [8:0] o_chain_cmd,
  output logic [8:0] o_logout,
  output logic [8:0] o_intq,
  output logic [8:0] o_init_ua,
  output logic [8:0] o_mpx_ua,
  output logic [8:0] o_ua_or,
  output logic [7:0] o_ls_addr,
  output logic [1:0] o_ls_word,
  output logic o_ls_clear_wr,
  output logic o_mr_flag,
  output logic o_mr_pulse
);

  // ====================================================================
  // Control register byte lanes
  logic ctl_load;
  logic [63:0] ctl_src;
  logic [71:0] ctl_bytes;
  logic [2:0] ctl_kind_reg;
  logic ctl_word_fetch;
  logic ctl_ucw1_fetch;

  // Status words come only from words 0, 2 and 3
  assign ctl_word_fetch = i_ls_fetch_to_ctl && (i_ls_word != ccr_pkg::WORD1);
  assign ctl_ucw1_fetch = i_manual_ls_fetch && (i_ls_word == ccr_pkg::WORD1);
  assign ctl_load = i_caw_load || ctl_word_fetch || ctl_ucw1_fetch;
  assign ctl_src = i_caw_load ? i_caw_data : i_ls_rdata;

  genvar g;
  generate
    for (g = 0; g < ccr_pkg::CTL_BYTES; g++) begin : g_ctl
      ccr_byte_reg u_lane (
        .i_clk(i_clk),
        .i_clear(i_master_reset),
        .i_load(ctl_load),
        .i_data(ctl_src[g*8 +: 8]),
        .o_byte(ctl_bytes[g*9 +: 9])
      );
      assign o_ctl_data[g*8 +: 8] = ctl_bytes[g*9 +: 8];
      assign o_ctl_par[g] = ctl_bytes[g*9 + 8];
    end
  endgenerate

  // ====================================================================
  // Control register kind
  always_ff @(posedge i_clk) begin
    if (i_master_reset) begin
      ctl_kind_reg <= ccr_pkg::CTL_EMPTY;
    end else if (i_caw_load) begin
      ctl_kind_reg <= ccr_pkg::CTL_CAW;
    end else if (ctl_ucw1_fetch) begin
      ctl_kind_reg <= ccr_pkg::CTL_UCW1;
    end else if (ctl_word_fetch) begin
      case (i_ls_word)
        ccr_pkg::WORD0: ctl_kind_reg <= ccr_pkg::CTL_CSW_W0;
        ccr_pkg::WORD2: ctl_kind_reg <= ccr_pkg::CTL_CSW_W2;
        ccr_pkg::WORD3: ctl_kind_reg <= ccr_pkg::CTL_CSW_W3;
        default: ctl_kind_reg <= ctl_kind_reg;
      endcase
    end
  end

  assign o_ctl_kind = ctl_kind_reg;

  // ====================================================================
  // Simulate I/O registers, untouched by machine reset
  logic mpx_sim_load;
  logic ssc_sim_load;

  assign mpx_sim_load = i_sim_mode && i_mpx_sim_write;
  assign ssc_sim_load = i_sim_mode && i_ssc_sim_write;

  ccr_byte_reg u_mpx_sim (
    .i_clk(i_clk),
    .i_clear(1'b0),
    .i_load(mpx_sim_load),
    .i_data(i_mpx_sim_data),
    .o_byte(o_mpx_sim)
  );

  ccr_byte_reg u_ssc_sim (
    .i_clk(i_clk),
    .i_clear(1'b0),
    .i_load(ssc_sim_load),
    .i_data(i_ssc_sim_data),
    .o_byte(o_ssc_sim)
  );

  // ====================================================================
  // Command, logout and queue registers
  ccr_byte_reg u_cmd (
    .i_clk(i_clk),
    .i_clear(i_master_reset),
    .i_load(i_start_ccw_fetch),
    .i_data(i_ccw_cmd),
    .o_byte(o_cmd)
  );

  ccr_byte_reg u_chain_cmd (
    .i_clk(i_clk),
    .i_clear(i_master_reset),
    .i_load(i_chain_ccw_fetch),
    .i_data(i_ccw_cmd),
    .o_byte(o_chain_cmd)
  );

  ccr_byte_reg u_logout (
    .i_clk(i_clk),
    .i_clear(i_master_reset),
    .i_load(i_login2),
    .i_data(i_log_addr),
    .o_byte(o_logout)
  );

  // Storage test writes the active address so the lane can be checked
  logic intq_load;
  logic [7:0] intq_src;

  assign intq_load = i_ibf_set || i_diag_ls_test;
  assign intq_src = i_ibf_set ? i_ibf_addr : o_ua_or[7:0];

  ccr_byte_reg u_intq (
    .i_clk(i_clk),
    .i_clear(i_master_reset),
    .i_load(intq_load),
    .i_data(intq_src),
    .o_byte(o_intq)
  );

  // ====================================================================
  // Unit address registers
  logic init_ua_load;
  logic [7:0] init_ua_src;
  logic mpx_ua_load;
  logic [7:0] mpx_ua_src;

  assign init_ua_load = i_cpu_ua_load || i_pseudo_test_io;
  assign init_ua_src = i_pseudo_test_io ? o_ua_or[7:0] : i_cpu_unit_address_lines;

  ccr_byte_reg u_init_ua (
    .i_clk(i_clk),
    .i_clear(i_master_reset),
    .i_load(init_ua_load),
    .i_data(init_ua_src),
    .o_byte(o_init_ua)
  );

  // Initial selection wins over a service request in the same cycle
  assign mpx_ua_load = i_mpx_init_sel || i_svc_req;
  assign mpx_ua_src = i_mpx_init_sel ? o_init_ua[7:0] : i_bus_in;

  ccr_byte_reg u_mpx_ua (
    .i_clk(i_clk),
    .i_clear(i_master_reset),
    .i_load(mpx_ua_load),
    .i_data(mpx_ua_src),
    .o_byte(o_mpx_ua)
  );

  // ====================================================================
  // Unit address OR
  logic [7:0] ua_or_next;
  logic [7:0] ua_or_reg;
  logic ua_or_par_reg;

  // A true OR: overlapping sequences merge rather than arbitrate
  always_comb begin
    ua_or_next = ccr_pkg::BYTE_CLEAR;
    if (i_seq_cpu) begin
      ua_or_next = ua_or_next | o_init_ua[7:0];
    end
    if (i_seq_mpx) begin
      ua_or_next = ua_or_next | o_mpx_ua[7:0];
    end
    if (i_seq_ssc) begin
      ua_or_next = ua_or_next | i_ssc_ua;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ua_or_reg <= ccr_pkg::BYTE_CLEAR;
      ua_or_par_reg <= ccr_pkg::PAR_CLEAR;
    end else begin
      ua_or_reg <= ua_or_next;
      ua_or_par_reg <= ~^ua_or_next;
    end
  end

  assign o_ua_or = {ua_or_par_reg, ua_or_reg};

  // ====================================================================
  // Master reset sequencer
  ccr_pkg::ccr_mr_state_type mr_state_reg;
  logic [10:0] mr_cnt_reg;
  logic [7:0] sweep_addr_reg;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mr_state_reg <= ccr_pkg::MR_IDLE;
      mr_cnt_reg <= ccr_pkg::CNT_ZERO;
      sweep_addr_reg <= ccr_pkg::LS_FIRST_ADDR;
    end else begin
      case (mr_state_reg)
        ccr_pkg::MR_IDLE: begin
          mr_cnt_reg <= ccr_pkg::CNT_ONE;
          if (i_master_reset) begin
            mr_state_reg <= ccr_pkg::MR_TIMING;
          end
        end
        ccr_pkg::MR_TIMING: begin
          // Released early: the reset was too short to clear storage
          if (!i_master_reset) begin
            mr_state_reg <= ccr_pkg::MR_IDLE;
          end else if (mr_cnt_reg == ccr_pkg::MR_CYCLES - ccr_pkg::CNT_ONE) begin
            mr_state_reg <= ccr_pkg::MR_SWEEP;
            sweep_addr_reg <= ccr_pkg::LS_FIRST_ADDR;
          end else begin
            mr_cnt_reg <= mr_cnt_reg + ccr_pkg::CNT_ONE;
          end
        end
        ccr_pkg::MR_SWEEP: begin
          // Pulse counts from zero so it spans the full pulse time
          mr_cnt_reg <= ccr_pkg::CNT_ZERO;
          if (sweep_addr_reg == ccr_pkg::LS_LAST_ADDR) begin
            mr_state_reg <= ccr_pkg::MR_PULSE;
          end else begin
            sweep_addr_reg <= sweep_addr_reg + 8'h01;
          end
        end
        ccr_pkg::MR_PULSE: begin
          if (mr_cnt_reg == ccr_pkg::MR_PULSE_CYCLES) begin
            if (!i_master_reset) begin
              mr_state_reg <= ccr_pkg::MR_IDLE;
            end
          end else begin
            mr_cnt_reg <= mr_cnt_reg + ccr_pkg::CNT_ONE;
          end
        end
        default: mr_state_reg <= ccr_pkg::MR_IDLE;
      endcase
    end
  end

  assign o_mr_flag = (mr_state_reg == ccr_pkg::MR_SWEEP);
  assign o_ls_clear_wr = o_mr_flag;
  assign o_mr_pulse = (mr_state_reg == ccr_pkg::MR_PULSE) &&
                      (mr_cnt_reg != ccr_pkg::MR_PULSE_CYCLES);

  // ====================================================================
  // Local store word select and address
  logic [1:0] ls_word_reg;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ls_word_reg <= ccr_pkg::WORD0;
    end else if (i_master_reset || i_diag_ls_test) begin
      ls_word_reg <= ccr_pkg::WORD1;
    end else if (i_ls_op) begin
      ls_word_reg <= i_ls_word;
    end
  end

  assign o_ls_word = o_mr_flag ? ccr_pkg::WORD1 : ls_word_reg;
  assign o_ls_addr = o_mr_flag ? sweep_addr_reg : ua_or_reg;

  // ====================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_ctl_mr_clear: assert property (i_master_reset |=>
    (o_ctl_data == 64'h0 && o_ctl_par == 8'hff))
    else $error("control register not cleared by master reset");

  a_ctl_holds: assert property (!i_master_reset && !ctl_load |=> $stable(o_ctl_data))
    else $error("control register changed without a load");

  a_ctl_ucw1: assert property (!i_master_reset && !i_caw_load && ctl_ucw1_fetch |=>
    (o_ctl_data == $past(i_ls_rdata) && o_ctl_kind == ccr_pkg::CTL_UCW1))
    else $error("word 1 fetch not shown in control register");

  a_sim_keep: assert property (@(posedge i_clk) !mpx_sim_load && !ssc_sim_load |=>
    ($stable(o_mpx_sim) && $stable(o_ssc_sim)))
    else $error("simulate register altered without a write");

  a_cmd_capture: assert property (!i_master_reset && i_start_ccw_fetch |=>
    (o_cmd[7:0] == $past(i_ccw_cmd) && o_cmd[8] == ~^$past(i_ccw_cmd)))
    else $error("command byte not captured with odd parity");

  a_chain_hold: assert property (!i_master_reset && !i_chain_ccw_fetch |=>
    $stable(o_chain_cmd))
    else $error("chained command register altered");

  a_logout_hold: assert property (!i_master_reset && !i_login2 |=> $stable(o_logout))
    else $error("logout register altered");

  a_psdo_ua: assert property (!i_master_reset && i_pseudo_test_io |=>
    o_init_ua[7:0] == $past(o_ua_or[7:0]))
    else $error("pseudo test did not load from address OR");

  a_mpx_ua_init: assert property (!i_master_reset && i_mpx_init_sel |=>
    o_mpx_ua[7:0] == $past(o_init_ua[7:0]))
    else $error("multiplex address not taken from initial address");

  a_or_parity: assert property (^o_ua_or == 1'b1)
    else $error("address OR parity not odd");

  a_mr_word1: assert property (o_mr_flag |-> ##1 o_ls_word == ccr_pkg::WORD1)
    else $error("word 1 not selected during storage clear");

  a_mr_flag_time: assert property ($rose(o_mr_flag) |->
    $past(mr_cnt_reg) == ccr_pkg::MR_CYCLES - ccr_pkg::CNT_ONE)
    else $error("master reset flag set before the full reset time");

  a_mr_sweep_len: assert property ($rose(o_mr_flag) |->
    ##256 $fell(o_mr_flag) ##0 o_mr_pulse)
    else $error("storage clear did not span all addresses");

  c_caw_load: cover property (i_caw_load ##1 o_ctl_kind == ccr_pkg::CTL_CAW);
  c_mr_done: cover property ($fell(o_mr_pulse));
  c_svc_req: cover property (i_svc_req && !i_mpx_init_sel);
  c_sim_write: cover property (mpx_sim_load ##1 ssc_sim_load);

endmodule : ccr_channel_regs
`default_nettype wire

// ---- sim/ccr_ls_model.sv ----
// Local storage model standing behind the channel register set.
// Assumes addresses and the clear strobe come from the register set on i_clk.
`timescale 1ns/100ps
`default_nettype none

module ccr_ls_model (
  input wire logic i_clk,
  input wire logic [7:0] i_addr,
  input wire logic [1:0] i_word,
  input wire logic i_clear_wr,
  output logic [63:0] o_rdata
);
  // ==================================================================
  // Storage, four words per unit address
  logic [63:0] mem [0:1023];

  // Read is combinational; unwritten words stay unknown on purpose
  assign o_rdata = mem[{i_addr, i_word}];

  // ==================================================================
  // Clear write from the master reset sweep
  // Plain always: the bench preloads words through the hierarchy
  always @(posedge i_clk) begin
    if (i_clear_wr) begin
      mem[{i_addr, i_word}] <= 64'h0;
    end
  end
endmodule : ccr_ls_model

`default_nettype wire

// ---- sim/ccr_channel_regs_tb.sv ----
// Self-checking bench for the channel control register set.
// Assumes the local storage model and 250 MHz clock; all inputs at falling edge.
`timescale 1ns/100ps
`default_nettype none

module ccr_channel_regs_tb;
  // ==================================================================
  // Stimulus and observed signals
  logic i_clk = 0, i_sys_rst = 1, i_master_reset = 0, i_caw_load = 0;
  logic i_ls_fetch_to_ctl = 0, i_manual_ls_fetch = 0, i_ls_op = 0, i_diag_ls_test = 0;
  logic i_sim_mode = 0, i_mpx_sim_write = 0, i_ssc_sim_write = 0;
  logic i_start_ccw_fetch = 0, i_chain_ccw_fetch = 0, i_login2 = 0, i_ibf_set = 0;
  logic i_cpu_ua_load = 0, i_pseudo_test_io = 0, i_mpx_init_sel = 0, i_svc_req = 0;
  logic i_seq_cpu = 0, i_seq_mpx = 0, i_seq_ssc = 0;
  logic [63:0] i_caw_data = 64'h0, i_ls_rdata;
  logic [1:0] i_ls_word = 2'h0;
  logic [7:0] i_mpx_sim_data = 8'h0, i_ssc_sim_data = 8'h0, i_ccw_cmd = 8'h0;
  logic [7:0] i_log_addr = 8'h0, i_ibf_addr = 8'h0, i_cpu_unit_address_lines = 8'h0;
  logic [7:0] i_bus_in = 8'h0, i_ssc_ua = 8'h0, o_ls_addr, o_ctl_par;
  logic [63:0] o_ctl_data;
  logic [2:0] o_ctl_kind;
  logic [8:0] o_mpx_sim, o_ssc_sim, o_cmd, o_chain_cmd, o_logout, o_intq;
  logic [8:0] o_init_ua, o_mpx_ua, o_ua_or;
  logic [1:0] o_ls_word;
  logic o_ls_clear_wr, o_mr_flag, o_mr_pulse;
  int fail_count = 0;
  int cmp_count = 0;

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch at %0t got %h expected %h", $time, (a), (b)); end end

  ccr_channel_regs u_dut (.i_clk, .i_sys_rst, .i_master_reset, .i_caw_load, .i_caw_data,
    .i_ls_fetch_to_ctl, .i_manual_ls_fetch, .i_ls_rdata, .i_ls_op, .i_ls_word,
    .i_diag_ls_test, .i_sim_mode, .i_mpx_sim_write, .i_mpx_sim_data, .i_ssc_sim_write,
    .i_ssc_sim_data, .i_start_ccw_fetch, .i_chain_ccw_fetch, .i_ccw_cmd, .i_login2,
    .i_log_addr, .i_ibf_set, .i_ibf_addr, .i_cpu_ua_load, .i_cpu_unit_address_lines,
    .i_pseudo_test_io, .i_mpx_init_sel, .i_svc_req, .i_bus_in, .i_seq_cpu, .i_seq_mpx,
    .i_seq_ssc, .i_ssc_ua, .o_ctl_data, .o_ctl_par, .o_ctl_kind, .o_mpx_sim, .o_ssc_sim,
    .o_cmd, .o_chain_cmd, .o_logout, .o_intq, .o_init_ua, .o_mpx_ua, .o_ua_or,
    .o_ls_addr, .o_ls_word, .o_ls_clear_wr, .o_mr_flag, .o_mr_pulse);

  ccr_ls_model u_ls (.i_clk(i_clk), .i_addr(o_ls_addr), .i_word(o_ls_word),
    .i_clear_wr(o_ls_clear_wr), .o_rdata(i_ls_rdata));

  always #2 i_clk = ~i_clk;

  // ==================================================================
  // Helpers
  task automatic nxt;
    @(negedge i_clk);
  endtask : nxt

  function automatic logic [8:0] pb(input logic [7:0] d);
    return {~^d, d};
  endfunction : pb

  function automatic logic [7:0] p64(input logic [63:0] d);
    logic [7:0] p;
    for (int g = 0; g < 8; g++) p[g] = ~^d[8*g +: 8];
    return p;
  endfunction : p64

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  // ==================================================================
  // Scenarios
  task automatic t_clear;
    i_master_reset = 1;
    nxt;
    i_master_reset = 0;
    nxt;
    `CHK(o_ctl_data, 64'h0)
    `CHK(o_ctl_par, 8'hff)
    `CHK(o_ctl_kind, 3'h0)
    `CHK(o_cmd, 9'h100)
    `CHK(o_chain_cmd, 9'h100)
    `CHK(o_logout, 9'h100)
    `CHK(o_intq, 9'h100)
    `CHK(o_init_ua, 9'h100)
    `CHK(o_mpx_ua, 9'h100)
    $display("test clear done");
  endtask : t_clear

  task automatic t_ctl;
    logic [63:0] e;
    logic [2:0] kinds [4] = '{3'h2, 3'h3, 3'h4, 3'h5};
    i_caw_data = 64'h0123456789abcdef;
    i_caw_load = 1;
    nxt;
    i_caw_load = 0;
    `CHK(o_ctl_data, 64'h0123456789abcdef)
    `CHK(o_ctl_par, p64(64'h0123456789abcdef))
    `CHK(o_ctl_kind, 3'h1)
    for (int w = 0; w < 4; w++) u_ls.mem[{8'h5a, 2'(w)}] = {16{4'(w + 1)}};
    for (int w = 0; w < 4; w++) begin
      e = {16{4'(w + 1)}};
      i_ls_word = 2'(w);
      i_ls_op = 1;
      nxt;
      i_ls_op = 0;
      `CHK(o_ls_word, 2'(w))
      `CHK(o_ls_addr, 8'h5a)
      if (w == 1) i_manual_ls_fetch = 1;
      else i_ls_fetch_to_ctl = 1;
      nxt;
      i_manual_ls_fetch = 0;
      i_ls_fetch_to_ctl = 0;
      nxt;
      `CHK(o_ctl_data, e)
      `CHK(o_ctl_par, p64(e))
      `CHK(o_ctl_kind, kinds[w])
    end
    $display("test control register done");
  endtask : t_ctl

  task automatic t_sim;
    i_sim_mode = 1;
    i_mpx_sim_data = 8'h3c;
    i_ssc_sim_data = 8'hc1;
    i_mpx_sim_write = 1;
    i_ssc_sim_write = 1;
    nxt;
    i_sim_mode = 0;
    i_mpx_sim_data = 8'h55;
    i_ssc_sim_data = 8'h07;
    `CHK(o_mpx_sim, pb(8'h3c))
    `CHK(o_ssc_sim, pb(8'hc1))
    nxt;
    i_mpx_sim_write = 0;
    i_ssc_sim_write = 0;
    i_sys_rst = 1;
    nxt;
    i_sys_rst = 0;
    nxt;
    `CHK(o_mpx_sim, pb(8'h3c))
    `CHK(o_ssc_sim, pb(8'hc1))
    $display("test simulate registers done");
  endtask : t_sim

  task automatic t_cmd;
    i_ccw_cmd = 8'h03;
    i_start_ccw_fetch = 1;
    nxt;
    i_start_ccw_fetch = 0;
    i_ccw_cmd = 8'h81;
    i_chain_ccw_fetch = 1;
    `CHK(o_cmd, pb(8'h03))
    nxt;
    i_chain_ccw_fetch = 0;
    `CHK(o_chain_cmd, pb(8'h81))
    `CHK(o_cmd, pb(8'h03))
    $display("test command registers done");
  endtask : t_cmd

  task automatic t_log;
    i_log_addr = 8'ha5;
    i_login2 = 1;
    nxt;
    i_login2 = 0;
    i_ibf_addr = 8'h12;
    i_ibf_set = 1;
    `CHK(o_logout, pb(8'ha5))
    nxt;
    i_ibf_set = 0;
    i_diag_ls_test = 1;
    `CHK(o_intq, pb(8'h12))
    `CHK(o_logout, pb(8'ha5))
    nxt;
    i_diag_ls_test = 0;
    `CHK(o_intq, pb(8'h5a))
    `CHK(o_ls_word, 2'h1)
    $display("test logout and queue done");
  endtask : t_log

  task automatic t_ua;
    i_cpu_unit_address_lines = 8'h21;
    i_cpu_ua_load = 1;
    nxt;
    i_cpu_ua_load = 0;
    i_mpx_init_sel = 1;
    `CHK(o_init_ua, pb(8'h21))
    nxt;
    i_mpx_init_sel = 0;
    i_bus_in = 8'h77;
    i_svc_req = 1;
    `CHK(o_mpx_ua, pb(8'h21))
    nxt;
    i_svc_req = 0;
    i_pseudo_test_io = 1;
    `CHK(o_mpx_ua, pb(8'h77))
    nxt;
    i_pseudo_test_io = 0;
    `CHK(o_init_ua, pb(8'h5a))
    `CHK(o_ua_or, pb(8'h5a))
    // Overlapping sequences merge their addresses
    i_seq_ssc = 0;
    i_seq_cpu = 1;
    i_seq_mpx = 1;
    nxt;
    `CHK(o_ua_or, pb(8'h7f))
    i_seq_cpu = 0;
    i_seq_mpx = 0;
    i_seq_ssc = 1;
    nxt;
    $display("test unit address done");
  endtask : t_ua

  task automatic t_mr;
    int n;
    u_ls.mem[{8'h5a, 2'h1}] = 64'hfeedfacecafe0001;
    i_master_reset = 1;
    n = 0;
    // Flag needs the full hold; a short count means the clear started early
    while (o_mr_flag !== 1'b1 && n < 2000) begin
      nxt;
      n++;
    end
    if (n >= 2000) begin
      fail_count++;
      test_done;
    end
    `CHK(n, 1500)
    for (int k = 0; k < 256; k++) begin
      `CHK(o_ls_addr, 8'(k))
      `CHK(o_ls_word, 2'h1)
      `CHK(o_ls_clear_wr, 1'b1)
      nxt;
    end
    `CHK(o_mr_flag, 1'b0)
    n = 0;
    while (o_mr_pulse === 1'b1 && n < 1000) begin
      nxt;
      n++;
    end
    `CHK(n, 500)
    i_master_reset = 0;
    i_ls_word = 2'h1;
    i_ls_op = 1;
    nxt;
    i_ls_op = 0;
    i_manual_ls_fetch = 1;
    nxt;
    i_manual_ls_fetch = 0;
    nxt;
    `CHK(o_ctl_data, 64'h0)
    `CHK(o_ctl_kind, 3'h3)
    $display("test master reset done");
  endtask : t_mr

  // ==================================================================
  // Main sequence
  initial begin
    i_seq_ssc = 1;
    i_ssc_ua = 8'h5a;
    // Simulate registers have no reset; define them while reset is held
    i_sim_mode = 1;
    i_mpx_sim_write = 1;
    i_ssc_sim_write = 1;
    repeat (10) @(posedge i_clk);
    nxt;
    i_sim_mode = 0;
    i_mpx_sim_write = 0;
    i_ssc_sim_write = 0;
    i_sys_rst = 0;
    t_clear;
    t_ctl;
    t_sim;
    t_cmd;
    t_log;
    t_ua;
    t_mr;
    test_done;
  end
endmodule : ccr_channel_regs_tb

`default_nettype wire
